/* hw/stack_flag_core.v */
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "stack_flag_defines.vh"

module stack_flag_core (
	input  wire        CLK,
	input  wire        RESET_N,
	input  wire [5:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	output wire [1:0]  S_AXI_BRESP,
	output wire        S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [5:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0]  S_AXI_RRESP,
	output wire        S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	output wire [15:0] MEM_ADDR,
	output wire [7:0]  MEM_WDATA,
	output wire        MEM_WE,
	output wire        MEM_RE,
	input  wire [7:0]  MEM_RDATA
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	reg        aw_full_r, w_full_r;
	reg [1:0]  bresp_r, rresp_r;
	reg [5:0]  awaddr_r;
	reg [31:0] wdata_r, rdata_r;
	reg [3:0]  wstrb_r;
	reg [7:0]  acc_r, b_r, c_r, d_r, e_r, h_r, l_r, operand_r;
	reg [15:0] stack_pointer_r;
	reg        carry_flag_r, parity_r, half_carry_flag_r, zero_r, sign_r;
	reg        busy_r, taken_r;
	reg [4:0]  cnt_r, total_r, last_states_r;
	reg [2:0]  op_r, sub_r;
	reg [1:0]  pair_r;
	reg [7:0]  tmp_lo_r, tmp_hi_r;
	reg        rd_lo_r, rd_hi_r;
	reg [15:0] mem_addr_r;
	reg [7:0]  mem_wdata_r;
	reg        mem_we_r, mem_re_r;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function [3:0] reg_index;
		input [5:0] addr;
		begin
			reg_index = addr[5:2];
		end
	endfunction

	function valid_index;
		input [5:0] addr;
		begin
			valid_index = (addr[5:2] <= reg_index(`OFS_STATUS));
		end
	endfunction

	wire [7:0] flag_byte;
	assign flag_byte = {sign_r, zero_r, 1'b0, half_carry_flag_r,
			1'b0, parity_r, 1'b1, carry_flag_r};

	// The pair selected by a command, as high and low byte.
	reg [7:0] pair_hi, pair_lo;
	always @* begin
		case (pair_r)
			`PAIR_BC: begin
				pair_hi = b_r;
				pair_lo = c_r;
			end
			`PAIR_DE: begin
				pair_hi = d_r;
				pair_lo = e_r;
			end
			`PAIR_HL: begin
				pair_hi = h_r;
				pair_lo = l_r;
			end
			default: begin
				pair_hi = acc_r;
				pair_lo = flag_byte;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Arithmetic and flag results
	// ----------------------------------------------------------------
	reg [8:0] sum;
	reg [4:0] nib;
	reg [7:0] res;
	reg       n_carry, n_half, wr_acc;
	always @* begin
		sum = 9'h000;
		nib = 5'h00;
		n_carry = carry_flag_r;
		wr_acc = 1'b1;
		case (sub_r)
			`ALU_ADD: begin
				sum = {1'b0, acc_r} + {1'b0, operand_r};
				nib = {1'b0, acc_r[3:0]} + {1'b0, operand_r[3:0]};
				n_carry = sum[8];
			end
			`ALU_SUB, `ALU_CMP: begin
				sum = {1'b0, acc_r} + {1'b0, ~operand_r} + 9'h001;
				nib = {1'b0, acc_r[3:0]} + {1'b0, ~operand_r[3:0]} + 5'h01;
				n_carry = (acc_r < operand_r);
				wr_acc = (sub_r == `ALU_SUB);
			end
			`ALU_AND: begin
				sum = {1'b0, acc_r & operand_r};
				n_carry = 1'b0;
			end
			`ALU_OR: begin
				sum = {1'b0, acc_r | operand_r};
				n_carry = 1'b0;
			end
			`ALU_XOR: begin
				sum = {1'b0, acc_r ^ operand_r};
				n_carry = 1'b0;
			end
			`ALU_INC: begin
				sum = {1'b0, acc_r} + 9'h001;
				nib = {1'b0, acc_r[3:0]} + 5'h01;
			end
			default: begin
				sum = {1'b0, acc_r} + 9'h0ff;
				nib = {1'b0, acc_r[3:0]} + 5'h0f;
			end
		endcase
		res = sum[7:0];
		n_half = nib[4];
	end

	// Condition of a conditional op: 0/1 zero, 2/3 carry, 4/5 parity, 6/7 sign.
	reg cond_flag, cond_true;
	always @* begin
		case (sub_r[2:1])
			2'h0: cond_flag = zero_r;
			2'h1: cond_flag = carry_flag_r;
			2'h2: cond_flag = parity_r;
			default: cond_flag = sign_r;
		endcase
		cond_true = (cond_flag == sub_r[0]);
	end

	// ----------------------------------------------------------------
	// AXI4-Lite channels
	// ----------------------------------------------------------------
	wire do_write;
	wire do_read;
	wire cmd_start;
	assign do_write = aw_full_r && w_full_r && !bvalid_r;
	assign do_read = arready_r && S_AXI_ARVALID;
	// Writes while an op runs are answered but dropped, so no byte changes mid-op.
	assign cmd_start = do_write && !busy_r && wstrb_r[0] &&
			(awaddr_r == `OFS_CMD);

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			bresp_r   <= 2'h0;
			awaddr_r  <= 6'h00;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
		end else begin
			if (awready_r && S_AXI_AWVALID) begin
				awaddr_r  <= S_AXI_AWADDR;
				aw_full_r <= 1'b1;
				awready_r <= 1'b0;
			end else if (!aw_full_r && !bvalid_r && !do_write) begin
				awready_r <= 1'b1;
			end
			if (wready_r && S_AXI_WVALID) begin
				wdata_r  <= S_AXI_WDATA;
				wstrb_r  <= S_AXI_WSTRB;
				w_full_r <= 1'b1;
				wready_r <= 1'b0;
			end else if (!w_full_r && !bvalid_r && !do_write) begin
				wready_r <= 1'b1;
			end
			if (do_write) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= valid_index(awaddr_r) ? 2'h0 : 2'h3;
			end else if (bvalid_r && S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= 2'h0;
			rdata_r   <= 32'h00000000;
		end else begin
			if (do_read) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rresp_r   <= valid_index(S_AXI_ARADDR) ? 2'h0 : 2'h3;
				case (reg_index(S_AXI_ARADDR))
					reg_index(`OFS_CMD):     rdata_r <= {24'h000000, op_r, 5'h00};
					reg_index(`OFS_ACC):     rdata_r <= {24'h000000, acc_r};
					reg_index(`OFS_REG_B):   rdata_r <= {24'h000000, b_r};
					reg_index(`OFS_REG_C):   rdata_r <= {24'h000000, c_r};
					reg_index(`OFS_REG_D):   rdata_r <= {24'h000000, d_r};
					reg_index(`OFS_REG_E):   rdata_r <= {24'h000000, e_r};
					reg_index(`OFS_REG_H):   rdata_r <= {24'h000000, h_r};
					reg_index(`OFS_REG_L):   rdata_r <= {24'h000000, l_r};
					reg_index(`OFS_STACK):   rdata_r <= {16'h0000, stack_pointer_r};
					reg_index(`OFS_FLAGS):   rdata_r <= {24'h000000, flag_byte};
					reg_index(`OFS_OPERAND): rdata_r <= {24'h000000, operand_r};
					reg_index(`OFS_STATUS):  rdata_r <= {19'h00000, last_states_r,
							6'h00, taken_r, busy_r};
					default:                 rdata_r <= 32'h00000000;
				endcase
			end else if (rvalid_r && S_AXI_RREADY) begin
				rvalid_r <= 1'b0;
			end else if (!rvalid_r) begin
				arready_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Operation sequencer, register file and stack access
	// ----------------------------------------------------------------
	wire last_state;
	wire [15:0] ptr_m1, ptr_m2, ptr_p1, ptr_p2;
	assign last_state = busy_r && (cnt_r == total_r - 5'h01);
	assign ptr_m1 = stack_pointer_r - 16'h0001;
	assign ptr_m2 = stack_pointer_r - 16'h0002;
	assign ptr_p1 = stack_pointer_r + 16'h0001;
	assign ptr_p2 = stack_pointer_r + 16'h0002;

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			acc_r <= `RST_REG8;
			b_r <= `RST_REG8;
			c_r <= `RST_REG8;
			d_r <= `RST_REG8;
			e_r <= `RST_REG8;
			h_r <= `RST_REG8;
			l_r <= `RST_REG8;
			operand_r <= `RST_REG8;
			stack_pointer_r <= `RST_STACK;
			carry_flag_r <= 1'b0;
			parity_r <= 1'b0;
			half_carry_flag_r <= 1'b0;
			zero_r <= 1'b0;
			sign_r <= 1'b0;
			busy_r <= 1'b0;
			taken_r <= 1'b0;
			cnt_r <= 5'h00;
			total_r <= 5'h01;
			last_states_r <= 5'h00;
			op_r <= 3'h0;
			sub_r <= 3'h0;
			pair_r <= 2'h0;
			tmp_lo_r <= 8'h00;
			tmp_hi_r <= 8'h00;
			rd_lo_r <= 1'b0;
			rd_hi_r <= 1'b0;
			mem_addr_r <= 16'h0000;
			mem_wdata_r <= 8'h00;
			mem_we_r <= 1'b0;
			mem_re_r <= 1'b0;
		end else begin
			mem_we_r <= 1'b0;
			mem_re_r <= 1'b0;
			rd_lo_r <= 1'b0;
			rd_hi_r <= 1'b0;
			if (rd_lo_r)
				tmp_lo_r <= MEM_RDATA;
			if (rd_hi_r)
				tmp_hi_r <= MEM_RDATA;
			if (cmd_start) begin
				busy_r <= 1'b1;
				cnt_r <= 5'h00;
				op_r <= wdata_r[`CMD_OP_LSB+2:`CMD_OP_LSB];
				pair_r <= wdata_r[`CMD_PAIR_LSB+1:`CMD_PAIR_LSB];
				sub_r <= wdata_r[`CMD_SUB_LSB+2:`CMD_SUB_LSB];
				case (wdata_r[`CMD_OP_LSB+2:`CMD_OP_LSB])
					`OP_PUSH: total_r <= `ST_PUSH;
					`OP_POP:  total_r <= `ST_POP;
					`OP_PTR_LOAD: total_r <= `ST_PTR_LOAD;
					`OP_TOP_SWAP: total_r <= `ST_TOP_SWAP;
					default:  total_r <= `ST_ALU;
				endcase
			end else if (do_write && !busy_r) begin
				if (wstrb_r[0]) begin
					case (awaddr_r)
						`OFS_ACC:     acc_r <= wdata_r[7:0];
						`OFS_REG_B:   b_r <= wdata_r[7:0];
						`OFS_REG_C:   c_r <= wdata_r[7:0];
						`OFS_REG_D:   d_r <= wdata_r[7:0];
						`OFS_REG_E:   e_r <= wdata_r[7:0];
						`OFS_REG_H:   h_r <= wdata_r[7:0];
						`OFS_REG_L:   l_r <= wdata_r[7:0];
						`OFS_OPERAND: operand_r <= wdata_r[7:0];
						`OFS_STACK:   stack_pointer_r[7:0] <= wdata_r[7:0];
						`OFS_FLAGS: begin
							carry_flag_r <= wdata_r[`FLB_CARRY];
							parity_r <= wdata_r[`FLB_PARITY];
							half_carry_flag_r <= wdata_r[`FLB_HALF];
							zero_r <= wdata_r[`FLB_ZERO];
							sign_r <= wdata_r[`FLB_SIGN];
						end
						default: ;
					endcase
				end
				if (wstrb_r[1] && awaddr_r == `OFS_STACK)
					stack_pointer_r[15:8] <= wdata_r[15:8];
			end
			if (busy_r) begin
				cnt_r <= cnt_r + 5'h01;
				// The conditional op decides its length in its first state.
				if (op_r == `OP_COND && cnt_r == 5'h00) begin
					total_r <= cond_true ? `ST_COND_T : `ST_COND_F;
					taken_r <= cond_true;
				end
				if (op_r == `OP_PUSH) begin
					if (cnt_r == `SLOT_A) begin
						mem_addr_r <= ptr_m1;
						mem_wdata_r <= pair_hi;
						mem_we_r <= 1'b1;
					end
					if (cnt_r == `SLOT_B) begin
						mem_addr_r <= ptr_m2;
						mem_wdata_r <= pair_lo;
						mem_we_r <= 1'b1;
					end
				end
				if (op_r == `OP_POP || op_r == `OP_TOP_SWAP) begin
					if (cnt_r == `SLOT_A) begin
						mem_addr_r <= stack_pointer_r;
						mem_re_r <= 1'b1;
						rd_lo_r <= 1'b1;
					end
					if (cnt_r == `SLOT_B) begin
						mem_addr_r <= ptr_p1;
						mem_re_r <= 1'b1;
						rd_hi_r <= 1'b1;
					end
				end
				if (op_r == `OP_TOP_SWAP) begin
					if (cnt_r == `SLOT_C) begin
						mem_addr_r <= stack_pointer_r;
						mem_wdata_r <= l_r;
						mem_we_r <= 1'b1;
					end
					if (cnt_r == `SLOT_D) begin
						mem_addr_r <= ptr_p1;
						mem_wdata_r <= h_r;
						mem_we_r <= 1'b1;
					end
				end
				if (last_state) begin
					busy_r <= 1'b0;
					last_states_r <= total_r;
					case (op_r)
						`OP_PUSH: stack_pointer_r <= ptr_m2;
						`OP_POP: begin
							stack_pointer_r <= ptr_p2;
							case (pair_r)
								`PAIR_BC: begin
									c_r <= tmp_lo_r;
									b_r <= tmp_hi_r;
								end
								`PAIR_DE: begin
									e_r <= tmp_lo_r;
									d_r <= tmp_hi_r;
								end
								`PAIR_HL: begin
									l_r <= tmp_lo_r;
									h_r <= tmp_hi_r;
								end
								default: begin
									carry_flag_r <= tmp_lo_r[`FLB_CARRY];
									parity_r <= tmp_lo_r[`FLB_PARITY];
									half_carry_flag_r <= tmp_lo_r[`FLB_HALF];
									zero_r <= tmp_lo_r[`FLB_ZERO];
									sign_r <= tmp_lo_r[`FLB_SIGN];
									acc_r <= tmp_hi_r;
								end
							endcase
						end
						`OP_PTR_LOAD: stack_pointer_r <= {h_r, l_r};
						`OP_TOP_SWAP: begin
							l_r <= tmp_lo_r;
							h_r <= tmp_hi_r;
						end
						`OP_ALU: begin
							if (wr_acc)
								acc_r <= res;
							sign_r <= res[7];
							zero_r <= (res == 8'h00);
							parity_r <= ~^res;
							carry_flag_r <= n_carry;
							half_carry_flag_r <= n_half;
						end
						default: ;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY  = wready_r;
	assign S_AXI_BRESP   = bresp_r;
	assign S_AXI_BVALID  = bvalid_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RDATA   = rdata_r;
	assign S_AXI_RRESP   = rresp_r;
	assign S_AXI_RVALID  = rvalid_r;
	assign MEM_ADDR      = mem_addr_r;
	assign MEM_WDATA     = mem_wdata_r;
	assign MEM_WE        = mem_we_r;
	assign MEM_RE        = mem_re_r;

endmodule // stack_flag_core

/* hw/stack_flag_defines.vh */
`ifndef STACK_FLAG_DEFINES_VH
`define STACK_FLAG_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD      6'h00
`define OFS_ACC      6'h04
`define OFS_REG_B    6'h08
`define OFS_REG_C    6'h0c
`define OFS_REG_D    6'h10
`define OFS_REG_E    6'h14
`define OFS_REG_H    6'h18
`define OFS_REG_L    6'h1c
`define OFS_STACK    6'h20
`define OFS_FLAGS    6'h24
`define OFS_OPERAND  6'h28
`define OFS_STATUS   6'h2c

// ----------------------------------------------------------------
// Command fields and codes
// ----------------------------------------------------------------
`define CMD_OP_LSB   0
`define CMD_PAIR_LSB 3
`define CMD_SUB_LSB  5
`define OP_PUSH      3'h0
`define OP_POP       3'h1
`define OP_PTR_LOAD  3'h2
`define OP_TOP_SWAP  3'h3
`define OP_ALU       3'h4
`define OP_COND      3'h5
`define PAIR_BC      2'h0
`define PAIR_DE      2'h1
`define PAIR_HL      2'h2
`define PAIR_AFW     2'h3
`define ALU_ADD      3'h0
`define ALU_SUB      3'h1
`define ALU_CMP      3'h2
`define ALU_AND      3'h3
`define ALU_OR       3'h4
`define ALU_XOR      3'h5
`define ALU_INC      3'h6
`define ALU_DEC      3'h7

// ----------------------------------------------------------------
// Flag byte layout and reset values
// ----------------------------------------------------------------
`define FLB_CARRY    0
`define FLB_ONE      1
`define FLB_PARITY   2
`define FLB_HALF     4
`define FLB_ZERO     6
`define FLB_SIGN     7
`define RST_REG8     8'h00
`define RST_STACK    16'h0000

// ----------------------------------------------------------------
// State counts and access slots
// ----------------------------------------------------------------
`define ST_PUSH      5'h0c
`define ST_POP       5'h0a
`define ST_PTR_LOAD  5'h06
`define ST_TOP_SWAP  5'h10
`define ST_ALU       5'h04
`define ST_COND_F    5'h05
`define ST_COND_T    5'h0b
`define SLOT_A       5'h03
`define SLOT_B       5'h06
`define SLOT_C       5'h09
`define SLOT_D       5'h0c

`endif

/* tb/stack_flag_core_properties.sv */
`timescale 1ns/1ps
`include "stack_flag_defines.vh"

module stack_flag_core_properties (
	input wire        CLK,
	input wire        RESET_N,
	input wire [5:0]  S_AXI_ARADDR,
	input wire        S_AXI_ARVALID,
	input wire        S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire        S_AXI_RVALID,
	input wire [15:0] MEM_ADDR,
	input wire        MEM_WE,
	input wire        MEM_RE
);
	reg flag_rd_r;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	// Remembers whether the read in flight targets the flag byte.
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			flag_rd_r <= 1'b0;
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
			flag_rd_r <= ({S_AXI_ARADDR[5:2], 2'b00} == `OFS_FLAGS);
	end

	property p_we_pulse;
		MEM_WE |=> !MEM_WE;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe longer than one cycle");

	property p_re_pulse;
		MEM_RE |=> !MEM_RE;
	endproperty
	a_re_pulse: assert property (p_re_pulse) else $error("read strobe longer than one cycle");

	property p_no_both;
		!(MEM_WE && MEM_RE);
	endproperty
	a_no_both: assert property (p_no_both) else $error("read and write strobes together");

	property p_wr_pair;
		MEM_WE ##3 MEM_WE |-> (MEM_ADDR == $past(MEM_ADDR, 3) - 16'h0001)
			|| (MEM_ADDR == $past(MEM_ADDR, 3) + 16'h0001);
	endproperty
	a_wr_pair: assert property (p_wr_pair) else $error("second stack write at wrong address");

	property p_rd_pair;
		MEM_RE ##3 MEM_RE |-> MEM_ADDR == $past(MEM_ADDR, 3) + 16'h0001;
	endproperty
	a_rd_pair: assert property (p_rd_pair) else $error("second stack read at wrong address");

	property p_exch_wr;
		MEM_RE ##3 MEM_RE ##3 MEM_WE |-> MEM_ADDR == $past(MEM_ADDR, 6);
	endproperty
	a_exch_wr: assert property (p_exch_wr) else $error("exchange wrote low byte elsewhere");

	property p_flag_fmt;
		S_AXI_RVALID && flag_rd_r |-> S_AXI_RDATA[1] && !S_AXI_RDATA[3] && !S_AXI_RDATA[5];
	endproperty
	a_flag_fmt: assert property (p_flag_fmt) else $error("flag byte fixed bits wrong");

	property p_flag_hi;
		S_AXI_RVALID && flag_rd_r |-> S_AXI_RDATA[31:8] == 24'h000000;
	endproperty
	a_flag_hi: assert property (p_flag_hi) else $error("flag word upper bits not zero");
endmodule // stack_flag_core_properties

/* tb/stack_mem_model.sv */
`timescale 1ns/1ps

// Stack memory; read data stands while the read strobe is high, since the core takes it
// at the edge that ends the strobe. Between reads the data bus toggles so stale data fails.
module stack_mem_model (
	input  wire        clk,
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	input  wire        mem_we,
	input  wire        mem_re,
	output wire [7:0]  mem_rdata
);
	reg [7:0] mem [0:65535];
	reg [7:0] idle_r;

	initial idle_r = 8'h00;

	always @(posedge clk) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		idle_r <= ~idle_r;
	end

	assign mem_rdata = mem_re ? mem[mem_addr] : idle_r;
endmodule // stack_mem_model

/* tb/tb.sv */
`timescale 1ns/1ps
`include "stack_flag_defines.vh"

module tb;
	localparam [47:0] RV = 48'h123456789abc;
	reg         CLK, RESET_N, awvalid, wvalid, bready, arvalid, rready;
	reg  [5:0]  awaddr, araddr;
	reg  [31:0] wdata, rdat;
	reg  [3:0]  wstrb;
	reg  [1:0]  resp;
	reg  [39:0] alu_tab [0:8];
	reg  [15:0] top;
	reg  [7:0]  hi, lo;
	reg  [3:0]  fv;
	reg         tk;
	wire        awready, wready, bvalid, arready, rvalid, mem_we, mem_re;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] mem_addr;
	wire [7:0]  mem_wdata, mem_rdata;
	integer     mismatches, cmp_count, i;

	stack_flag_core i_stack_flag_core (.CLK(CLK), .RESET_N(RESET_N),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we), .MEM_RE(mem_re),
		.MEM_RDATA(mem_rdata));

	stack_mem_model i_stack_mem_model (.clk(CLK), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic check(input [31:0] seen, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task automatic wr(input [5:0] a, input [31:0] d, output [1:0] r);
		integer n;
		reg     aw, w, b;
		begin
			@(posedge CLK);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			aw = 1'b0;
			w = 1'b0;
			b = 1'b0;
			n = 0;
			while (!b && n < 60) begin
				@(posedge CLK);
				n = n + 1;
				if (!aw && awready === 1'b1) begin
					aw = 1'b1;
					awvalid <= 1'b0;
				end
				if (!w && wready === 1'b1) begin
					w = 1'b1;
					wvalid <= 1'b0;
				end
				if (bvalid === 1'b1) begin
					b = 1'b1;
					r = bresp;
					bready <= 1'b0;
				end
			end
			if (!b)
				check(32'h0, 32'h1);
		end
	endtask

	task automatic rd(input [5:0] a, output [31:0] d, output [1:0] r);
		integer n;
		reg     ar, b;
		begin
			@(posedge CLK);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			ar = 1'b0;
			b = 1'b0;
			n = 0;
			while (!b && n < 60) begin
				@(posedge CLK);
				n = n + 1;
				if (!ar && arready === 1'b1) begin
					ar = 1'b1;
					arvalid <= 1'b0;
				end
				if (rvalid === 1'b1) begin
					b = 1'b1;
					d = rdata;
					r = rresp;
					rready <= 1'b0;
				end
			end
			if (!b)
				check(32'h0, 32'h1);
		end
	endtask

	task automatic chk(input [5:0] a, input [31:0] exp);
		begin
			rd(a, rdat, resp);
			check(rdat, exp);
		end
	endtask

	// Issues a command, polls until idle and leaves the status word in rdat.
	task automatic run(input [7:0] cmd, input [4:0] cnt);
		integer n;
		begin
			wr(`OFS_CMD, {24'h0, cmd}, resp);
			n = 0;
			rdat = 32'h1;
			while (rdat[0] !== 1'b0 && n < 40) begin
				rd(`OFS_STATUS, rdat, resp);
				n = n + 1;
			end
			check(rdat[12:8], cnt);
		end
	endtask

	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
			if (mismatches == 0 && cmp_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	// Bounded by a generous multiple of the fewer than 1000 cycles the sequence needs.
	initial begin
		#(25 * 20000);
		mismatches = mismatches + 1;
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{RESET_N, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 44'h0;
		wstrb = 4'hf;
		mismatches = 0;
		cmp_count = 0;
		// Op, accumulator, operand, result, flag byte.
		alu_tab[0] = 40'h00_8f_71_00_57;
		alu_tab[1] = 40'h01_05_03_02_12;
		alu_tab[2] = 40'h02_20_20_20_56;
		alu_tab[3] = 40'h02_10_20_10_97;
		alu_tab[4] = 40'h03_f0_3c_30_06;
		alu_tab[5] = 40'h04_01_80_81_86;
		alu_tab[6] = 40'h05_55_54_01_02;
		alu_tab[7] = 40'h06_0f_00_10_13;
		alu_tab[8] = 40'h07_00_00_ff_87;
		repeat (5) @(posedge CLK);
		RESET_N <= 1'b1;
		chk(`OFS_STACK, 32'h0);
		chk(`OFS_FLAGS, 32'h02);
		wr(`OFS_FLAGS, 32'hff, resp);
		chk(`OFS_FLAGS, 32'hd7);
		for (i = 0; i < 6; i = i + 1)
			wr(6'(`OFS_REG_B + 4 * i), {24'h0, RV[47 - 8 * i -: 8]}, resp);
		wr(`OFS_ACC, 32'ha5, resp);
		top = 16'h1000;
		wr(`OFS_STACK, {16'h0, top}, resp);
		for (i = 0; i < 4; i = i + 1) begin
			hi = (i == 3) ? 8'ha5 : RV[47 - 16 * i -: 8];
			lo = (i == 3) ? 8'hd7 : RV[39 - 16 * i -: 8];
			run({3'h0, i[1:0], `OP_PUSH}, `ST_PUSH);
			check(i_stack_mem_model.mem[top - 16'h1], hi);
			check(i_stack_mem_model.mem[top - 16'h2], lo);
			top = top - 16'h2;
			chk(`OFS_STACK, {16'h0, top});
		end
		i_stack_mem_model.mem[16'h0ff8] = 8'h44;
		i_stack_mem_model.mem[16'h0ff9] = 8'h3c;
		run({3'h0, `PAIR_AFW, `OP_POP}, `ST_POP);
		chk(`OFS_FLAGS, 32'h46);
		chk(`OFS_ACC, 32'h3c);
		chk(`OFS_STACK, 32'h0ffa);
		run({3'h0, `PAIR_BC, `OP_POP}, `ST_POP);
		chk(`OFS_REG_C, 32'hbc);
		chk(`OFS_REG_B, 32'h9a);
		chk(`OFS_STACK, 32'h0ffc);
		run({3'h0, 2'h0, `OP_TOP_SWAP}, `ST_TOP_SWAP);
		chk(`OFS_REG_L, 32'h78);
		chk(`OFS_REG_H, 32'h56);
		check(i_stack_mem_model.mem[16'h0ffc], 8'hbc);
		check(i_stack_mem_model.mem[16'h0ffd], 8'h9a);
		chk(`OFS_STACK, 32'h0ffc);
		run({3'h0, 2'h0, `OP_PTR_LOAD}, `ST_PTR_LOAD);
		chk(`OFS_STACK, 32'h5678);
		for (i = 0; i < 9; i = i + 1) begin
			wr(`OFS_FLAGS, 32'h01, resp);
			wr(`OFS_ACC, alu_tab[i][31:24], resp);
			wr(`OFS_OPERAND, alu_tab[i][23:16], resp);
			run({alu_tab[i][34:32], 2'h0, `OP_ALU}, `ST_ALU);
			chk(`OFS_ACC, alu_tab[i][15:8]);
			chk(`OFS_FLAGS, alu_tab[i][7:0]);
		end
		wr(`OFS_FLAGS, 32'h41, resp);
		fv = 4'b0011;
		for (i = 0; i < 8; i = i + 1) begin
			tk = (fv[i >> 1] == i[0]);
			run({i[2:0], 2'h0, `OP_COND}, tk ? `ST_COND_T : `ST_COND_F);
			check(rdat[1], tk);
			chk(`OFS_FLAGS, 32'h43);
		end
		rd(6'h30, rdat, resp);
		check(rdat, 32'h0);
		check({30'h0, resp}, 32'h3);
		wr(6'h3c, 32'h5a, resp);
		check(resp, 2'h3);
		tally_and_finish;
	end
endmodule // tb

bind stack_flag_core stack_flag_core_properties i_stack_flag_core_properties (.CLK(CLK),
	.RESET_N(RESET_N), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE));
